// ---- tsm_pkg.sv ----
// Constants, register map and types for the test-signal observation mux
package tsm_pkg;

  localparam int TSM_ADDR_W = 8;
  localparam int TSM_DATA_W = 32;

  // Register byte offsets
  localparam logic [TSM_ADDR_W-1:0] TSM_OFS_CTRL = 8'h00;
  localparam logic [TSM_ADDR_W-1:0] TSM_OFS_DIGI = 8'h04;
  localparam logic [TSM_ADDR_W-1:0] TSM_OFS_ANA = 8'h08;
  localparam logic [TSM_ADDR_W-1:0] TSM_OFS_STAT = 8'h0C;

  // Control register layout
  localparam int CTRL_ROUTE_BIT = 0;
  localparam int CTRL_SRC_LSB = 1;
  localparam int CTRL_SRC_W = 3;

  // Digital probe register: full byte kept, field is the low seven bits
  localparam int DIGI_REG_W = 8;
  localparam int DIGI_FIELD_W = 7;

  // Analog probe field
  localparam int ANA_FIELD_W = 5;
  localparam int ANA_NODES = 13;

  // Status register layout
  localparam int STAT_OUT_BIT = 0;
  localparam int STAT_RATE_BIT = 1;
  localparam int STAT_DIGI_ACT_BIT = 2;
  localparam int STAT_DIGI_KNOWN_BIT = 3;
  localparam int STAT_ANA_RSVD_BIT = 4;
  localparam int STAT_BLOCKED_BIT = 5;
  localparam int STAT_SRC_RSVD_BIT = 6;

  // Reset values
  localparam logic [CTRL_SRC_W-1:0] SRC_RESET = 3'h0;
  localparam logic [DIGI_REG_W-1:0] DIGI_RESET = 8'h00;
  localparam logic [ANA_FIELD_W-1:0] ANA_RESET = 5'h00;

  // Digital probe codes
  localparam logic [DIGI_REG_W-1:0] DIGI_NONE = 8'h00;
  localparam logic [DIGI_REG_W-1:0] DIGI_RX_VALUE = 8'hF4;
  localparam logic [DIGI_REG_W-1:0] DIGI_RX_QUAL = 8'hE4;
  localparam logic [DIGI_REG_W-1:0] DIGI_RX_COLL = 8'hD4;
  localparam logic [DIGI_REG_W-1:0] DIGI_SER_CLK = 8'hC4;
  localparam logic [DIGI_REG_W-1:0] DIGI_HOST_RD = 8'hB5;
  localparam logic [DIGI_REG_W-1:0] DIGI_HOST_WR = 8'hA5;
  localparam logic [DIGI_REG_W-1:0] DIGI_CARRIER = 8'h96;
  localparam logic [DIGI_REG_W-1:0] DIGI_PSK_OUT = 8'h83;
  localparam logic [DIGI_REG_W-1:0] DIGI_PSK_AMP = 8'hE2;

  localparam int DIGI_CODE_COUNT = 9;
  // Index i of this table selects bit i of the probe signal vector
  localparam logic [DIGI_REG_W-1:0] DIGI_CODES [DIGI_CODE_COUNT] = '{
    DIGI_RX_VALUE, DIGI_RX_QUAL, DIGI_RX_COLL, DIGI_SER_CLK, DIGI_HOST_RD,
    DIGI_HOST_WR, DIGI_CARRIER, DIGI_PSK_OUT, DIGI_PSK_AMP};

  typedef enum logic [CTRL_SRC_W-1:0] {
    SRC_LOW,
    SRC_HIGH,
    SRC_ENVELOPE,
    SRC_TX_NRZ,
    SRC_MANCH_SUBC,
    SRC_MANCH,
    SRC_RSVD_A,
    SRC_RSVD_B
  } tsm_mux_src_t;

  typedef struct packed {
    logic route;
    logic [CTRL_SRC_W-1:0] srcSel;
    logic [DIGI_REG_W-1:0] digiSel;
    logic [ANA_FIELD_W-1:0] anaSel;
    logic testOut;
    logic [ANA_NODES-1:0] anaEn;
    logic blockedSeen;
    logic [TSM_DATA_W-1:0] rdata;
  } tsm_state_t;

endpackage : tsm_pkg

// ---- tsm_digital_sel.sv ----
// Decoder that picks one digital probe signal by its code
`timescale 1ns/10ps
module tsm_digital_sel (
  input wire logic [tsm_pkg::DIGI_REG_W-1:0] probeCode,
  input wire logic [tsm_pkg::DIGI_CODE_COUNT-1:0] probeSignals,
  output logic probeBit,
  output logic probeKnown
);
  import tsm_pkg::*;

  logic [DIGI_CODE_COUNT-1:0] codeHit;

  genvar i;
  generate
    for (i = 0; i < DIGI_CODE_COUNT; i++) begin : g_code
      assign codeHit[i] = (probeCode == DIGI_CODES[i]);
    end
  endgenerate

  // Codes are distinct, so at most one hit; unknown codes give low
  assign probeBit = |(codeHit & probeSignals);
  assign probeKnown = |codeHit;

endmodule : tsm_digital_sel

// ---- tsm_analog_sel.sv ----
// One-hot decoder of the analog probe field onto node switch enables
`timescale 1ns/10ps
module tsm_analog_sel (
  input wire logic [tsm_pkg::ANA_FIELD_W-1:0] anaField,
  output logic [tsm_pkg::ANA_NODES-1:0] nodeEnable,
  output logic anaReserved
);
  import tsm_pkg::*;

  genvar i;
  generate
    for (i = 0; i < ANA_NODES; i++) begin : g_node
      assign nodeEnable[i] = (anaField == ANA_FIELD_W'(i));
    end
  endgenerate

  // Reserved values close every switch so no node reaches the pin
  assign anaReserved = ~|nodeEnable;

endmodule : tsm_analog_sel

// ---- tsm_top.sv ----
// Test-signal observation mux with APB register access
//
// Behaviour
// - Route low: test output follows 3-bit source select; 110 and 111 reserved.
// - Manchester selections pass only at 106 kBd type A; otherwise held low.
// - Route high with a nonzero probe code: digital probe signal drives output, source select ignored.
// - Probe code F4h selects received data bit.
// - Probe code E4h selects received bit qualifier.
// - Probe code D4h selects bit collision indicator.
// - Probe code C4h selects serial bit clock of encoder or receiver.
// - Codes B5h and A5h select synchronized host read and write strobes.
// - Code 96h selects core carrier clock; 83h selects PSK demodulator output.
// - Code E2h selects PSK amplitude detected indicator.
// - Probe code 00h: output follows source select even with route high.
// - 5-bit analog field picks node 0 to C; D to 1F reserved.
`timescale 1ns/10ps
module tsm_top (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tsm_pkg::TSM_ADDR_W-1:0] paddr,
  input wire logic [tsm_pkg::TSM_DATA_W-1:0] pwdata,
  output logic [tsm_pkg::TSM_DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rate106TypeA,
  input wire logic envelope,
  input wire logic txNrz,
  input wire logic manchSubcarrier,
  input wire logic manchester,
  input wire logic rxBitValue,
  input wire logic rxBitQualifier,
  input wire logic rxBitCollision,
  input wire logic serialBitClock,
  input wire logic hostReadStrobeSynced,
  input wire logic hostWriteStrobeSynced,
  input wire logic coreCarrierClock,
  input wire logic pskDemodOutput,
  input wire logic pskAmplitudeSeen,
  output logic muxTestOut,
  output logic [tsm_pkg::ANA_NODES-1:0] analogNodeEnable
);
  import tsm_pkg::*;

  tsm_state_t state_ff;
  tsm_state_t nxt_state;

  logic setupPhase;
  logic accessPhase;
  logic wrEn;
  logic addrHit;
  logic [TSM_DATA_W-1:0] rdMux;

  tsm_mux_src_t srcSel;
  logic muxBit;
  logic blockedNow;
  logic srcReserved;
  logic digiActive;

  logic [DIGI_CODE_COUNT-1:0] probeVec;
  logic probeBit;
  logic probeKnown;
  logic [ANA_NODES-1:0] anaOneHot;
  logic anaReserved;

  // Bus phases; the slave never inserts wait states
  assign setupPhase = psel & ~penable;
  assign accessPhase = psel & penable;
  assign wrEn = accessPhase & pwrite & addrHit;
  assign pready = 1'b1;
  assign pslverr = accessPhase & ~addrHit;

  always_comb begin
    case (paddr)
      TSM_OFS_CTRL: addrHit = 1'b1;
      TSM_OFS_DIGI: addrHit = 1'b1;
      TSM_OFS_ANA: addrHit = 1'b1;
      TSM_OFS_STAT: addrHit = 1'b1;
      default: addrHit = 1'b0;
    endcase
  end

  // Order of this vector matches the code table in the package
  assign probeVec = {
    pskAmplitudeSeen,
    pskDemodOutput,
    coreCarrierClock,
    hostWriteStrobeSynced,
    hostReadStrobeSynced,
    serialBitClock,
    rxBitCollision,
    rxBitQualifier,
    rxBitValue
  };

  tsm_digital_sel u_digital_sel (
    .probeCode(state_ff.digiSel),
    .probeSignals(probeVec),
    .probeBit(probeBit),
    .probeKnown(probeKnown)
  );

  tsm_analog_sel u_analog_sel (
    .anaField(state_ff.anaSel),
    .nodeEnable(anaOneHot),
    .anaReserved(anaReserved)
  );

  // Digital probe only takes over when routed and a code is set
  assign digiActive = state_ff.route & (state_ff.digiSel != DIGI_NONE);

  // Serial signal switch
  always_comb begin
    srcSel = tsm_mux_src_t'(state_ff.srcSel);
    muxBit = 1'b0;
    blockedNow = 1'b0;
    srcReserved = 1'b0;
    case (srcSel)
      SRC_LOW: begin
        muxBit = 1'b0;
      end
      SRC_HIGH: begin
        muxBit = 1'b1;
      end
      SRC_ENVELOPE: begin
        muxBit = envelope;
      end
      SRC_TX_NRZ: begin
        muxBit = txNrz;
      end
      SRC_MANCH_SUBC: begin
        // Decoder output is meaningless at other rates, so hold it low
        muxBit = manchSubcarrier & rate106TypeA;
        blockedNow = ~rate106TypeA;
      end
      SRC_MANCH: begin
        muxBit = manchester & rate106TypeA;
        blockedNow = ~rate106TypeA;
      end
      default: begin
        // Reserved sources give a quiet low pin
        muxBit = 1'b0;
        srcReserved = 1'b1;
      end
    endcase
  end

  // Read-back image
  always_comb begin
    rdMux = '0;
    case (paddr)
      TSM_OFS_CTRL: begin
        rdMux[CTRL_ROUTE_BIT] = state_ff.route;
        rdMux[CTRL_SRC_LSB +: CTRL_SRC_W] = state_ff.srcSel;
      end
      TSM_OFS_DIGI: begin
        rdMux[DIGI_REG_W-1:0] = state_ff.digiSel;
      end
      TSM_OFS_ANA: begin
        rdMux[ANA_FIELD_W-1:0] = state_ff.anaSel;
      end
      TSM_OFS_STAT: begin
        rdMux[STAT_OUT_BIT] = state_ff.testOut;
        rdMux[STAT_RATE_BIT] = rate106TypeA;
        rdMux[STAT_DIGI_ACT_BIT] = digiActive;
        rdMux[STAT_DIGI_KNOWN_BIT] = probeKnown;
        rdMux[STAT_ANA_RSVD_BIT] = anaReserved;
        rdMux[STAT_BLOCKED_BIT] = state_ff.blockedSeen;
        rdMux[STAT_SRC_RSVD_BIT] = srcReserved;
      end
      default: begin
        rdMux = '0;
      end
    endcase
  end

  always_comb begin
    nxt_state = state_ff;

    if (wrEn) begin
      case (paddr)
        TSM_OFS_CTRL: begin
          nxt_state.route = pwdata[CTRL_ROUTE_BIT];
          nxt_state.srcSel = pwdata[CTRL_SRC_LSB +: CTRL_SRC_W];
        end
        TSM_OFS_DIGI: begin
          // Whole byte kept so codes with the top bit set read back intact
          nxt_state.digiSel = pwdata[DIGI_REG_W-1:0];
        end
        TSM_OFS_ANA: begin
          nxt_state.anaSel = pwdata[ANA_FIELD_W-1:0];
        end
        default: begin
          nxt_state.route = state_ff.route;
        end
      endcase
    end

    // Sticky: software clears by writing one, a new event wins the clear
    if (wrEn && (paddr == TSM_OFS_STAT) && pwdata[STAT_BLOCKED_BIT]) begin
      nxt_state.blockedSeen = 1'b0;
    end
    if (blockedNow && !digiActive) begin
      nxt_state.blockedSeen = 1'b1;
    end

    // Outputs follow the stored selection one edge later
    nxt_state.testOut = digiActive ? probeBit : muxBit;
    nxt_state.anaEn = anaOneHot;

    // Read data is caught in the setup cycle and held through access
    if (setupPhase && !pwrite) begin
      nxt_state.rdata = rdMux;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff.route <= 1'b0;
      state_ff.srcSel <= SRC_RESET;
      state_ff.digiSel <= DIGI_RESET;
      state_ff.anaSel <= ANA_RESET;
      state_ff.testOut <= 1'b0;
      state_ff.anaEn <= '0;
      state_ff.blockedSeen <= 1'b0;
      state_ff.rdata <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign prdata = state_ff.rdata;
  assign muxTestOut = state_ff.testOut;
  assign analogNodeEnable = state_ff.anaEn;

endmodule : tsm_top

// ---- tsm_top_asserts.sv ----
// Assertion checker for the test-signal observation mux
`timescale 1ns/10ps
module tsm_top_asserts (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tsm_pkg::TSM_ADDR_W-1:0] paddr,
  input wire logic [tsm_pkg::TSM_DATA_W-1:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic rate106TypeA,
  input wire logic envelope,
  input wire logic txNrz,
  input wire logic manchSubcarrier,
  input wire logic manchester,
  input wire logic rxBitValue,
  input wire logic rxBitQualifier,
  input wire logic rxBitCollision,
  input wire logic serialBitClock,
  input wire logic hostReadStrobeSynced,
  input wire logic hostWriteStrobeSynced,
  input wire logic coreCarrierClock,
  input wire logic pskDemodOutput,
  input wire logic pskAmplitudeSeen,
  input wire logic muxTestOut,
  input wire logic [tsm_pkg::ANA_NODES-1:0] analogNodeEnable
);
  import tsm_pkg::*;
  logic [3:0] ctrl_ff;
  logic [7:0] digi_ff;
  logic [4:0] ana_ff;
  logic [8:0] pv;
  logic probeOn, srcBit, probeBit;
  logic [12:0] expAna;
  // Shadow copies of the selection registers, rebuilt from bus writes
  assign pv = {pskAmplitudeSeen, pskDemodOutput, coreCarrierClock, hostWriteStrobeSynced,
    hostReadStrobeSynced, serialBitClock, rxBitCollision, rxBitQualifier, rxBitValue};
  assign probeOn = ctrl_ff[0] && digi_ff != 8'h00;
  assign expAna = ana_ff < 5'h0D ? 13'h0001 << ana_ff : 13'h0000;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_ff <= 4'h0;
      digi_ff <= 8'h00;
      ana_ff <= 5'h00;
    end else if (psel && penable && pwrite && pready) begin
      if (paddr == TSM_OFS_CTRL) ctrl_ff <= pwdata[3:0];
      if (paddr == TSM_OFS_DIGI) digi_ff <= pwdata[7:0];
      if (paddr == TSM_OFS_ANA) ana_ff <= pwdata[4:0];
    end
  end
  always_comb begin
    probeBit = 1'h0;
    for (int i = 0; i < DIGI_CODE_COUNT; i++) begin
      if (digi_ff == DIGI_CODES[i]) probeBit = pv[i];
    end
    case (ctrl_ff[3:1])
      3'h1: srcBit = 1'h1;
      3'h2: srcBit = envelope;
      3'h3: srcBit = txNrz;
      3'h4: srcBit = manchSubcarrier && rate106TypeA;
      3'h5: srcBit = manchester && rate106TypeA;
      default: srcBit = 1'h0;
    endcase
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  AST_SRC_PATH: assert property (!probeOn |=> muxTestOut == $past(srcBit))
    else $error("source select path wrong");
  AST_PROBE_PATH: assert property (probeOn |=> muxTestOut == $past(probeBit))
    else $error("digital probe path wrong");
  AST_MANCH_BLOCK: assert property (!probeOn && ctrl_ff[3:2] == 2'h2 && !rate106TypeA |=> !muxTestOut)
    else $error("manchester passed at wrong rate");
  AST_ANA_MAP: assert property (1'h1 |=> analogNodeEnable == $past(expAna))
    else $error("analog node enable wrong");
  AST_ANA_ONEHOT: assert property ($onehot0(analogNodeEnable))
    else $error("several analog nodes enabled");
  AST_READY: assert property (psel && penable |-> pready)
    else $error("access not completed");
  AST_ERR_MAP: assert property (psel && penable |-> pslverr == (paddr > TSM_OFS_STAT || paddr[1:0] != 2'h0))
    else $error("slave error does not match address");
  AST_ERR_IDLE: assert property (!(psel && penable) |-> !pslverr)
    else $error("slave error outside access");
  COV_PROBE: cover property (probeOn && muxTestOut);
  COV_BLOCK: cover property (!probeOn && ctrl_ff[3:2] == 2'h2 && !rate106TypeA && manchester);
  COV_ERR: cover property (pslverr);
endmodule : tsm_top_asserts

bind tsm_top tsm_top_asserts u_tsm_top_asserts (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .rate106TypeA(rate106TypeA), .envelope(envelope), .txNrz(txNrz), .manchSubcarrier(manchSubcarrier),
  .manchester(manchester), .rxBitValue(rxBitValue), .rxBitQualifier(rxBitQualifier),
  .rxBitCollision(rxBitCollision), .serialBitClock(serialBitClock), .hostReadStrobeSynced(hostReadStrobeSynced),
  .hostWriteStrobeSynced(hostWriteStrobeSynced), .coreCarrierClock(coreCarrierClock),
  .pskDemodOutput(pskDemodOutput), .pskAmplitudeSeen(pskAmplitudeSeen), .muxTestOut(muxTestOut),
  .analogNodeEnable(analogNodeEnable));

// ---- tsm_probe_meter.sv ----
// Instrument model that samples the observed test pins
`timescale 1ns/10ps
module tsm_probe_meter (
  input wire logic clk,
  input wire logic muxTestOut,
  input wire logic [tsm_pkg::ANA_NODES-1:0] analogNodeEnable,
  output logic seenOut,
  output logic [tsm_pkg::ANA_NODES-1:0] seenNodes
);
  import tsm_pkg::*;
  // A scope only sees the pins at its own sample points, one clock late
  always_ff @(posedge clk) begin
    seenOut <= muxTestOut;
    seenNodes <= analogNodeEnable;
  end
endmodule : tsm_probe_meter

// ---- tb_top.sv ----
// Self-checking bench for the test-signal observation mux
`timescale 1ns/10ps
module tb_top;
  import tsm_pkg::*;
  logic clk, arst_n, psel, penable, pwrite, pready, pslverr, rate106TypeA, muxTestOut, seenOut, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] srcVec, oh;
  logic [8:0] probeVec;
  logic [12:0] analogNodeEnable, seenNodes;
  int err_count, samples_checked;
  tsm_top u_tsm_top (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rate106TypeA(rate106TypeA), .envelope(srcVec[0]), .txNrz(srcVec[1]), .manchSubcarrier(srcVec[2]),
    .manchester(srcVec[3]), .rxBitValue(probeVec[0]), .rxBitQualifier(probeVec[1]),
    .rxBitCollision(probeVec[2]), .serialBitClock(probeVec[3]), .hostReadStrobeSynced(probeVec[4]),
    .hostWriteStrobeSynced(probeVec[5]), .coreCarrierClock(probeVec[6]), .pskDemodOutput(probeVec[7]),
    .pskAmplitudeSeen(probeVec[8]), .muxTestOut(muxTestOut), .analogNodeEnable(analogNodeEnable));
  tsm_probe_meter u_tsm_probe_meter (.clk(clk), .muxTestOut(muxTestOut),
    .analogNodeEnable(analogNodeEnable), .seenOut(seenOut), .seenNodes(seenNodes));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (n >= 16) begin
      err_count++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : xfer
  // Three edges: register the output, meter sample, one spare edge of margin
  task automatic look(input logic [31:0] exp);
    repeat (3) @(posedge clk);
    #1;
    chk("muxTestOut", 32'(seenOut), exp);
  endtask : look
  initial begin
    {psel, penable, pwrite, paddr, pwdata, rate106TypeA, srcVec, probeVec, arst_n} = '0;
    err_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge clk);
    arst_n <= 1'h1;
    for (int a = 0; a < 16; a += 4) begin
      xfer(1'h0, 8'(a), 32'h0);
      chk("reset value", rd, 32'h0);
      chk("pslverr", 32'(er), 32'h0);
    end
    xfer(1'h0, 8'h10, 32'h0);
    chk("unmapped pslverr", 32'(er), 32'h1);
    chk("unmapped data", rd, 32'h0);
    for (int c = 0; c < 8; c++) begin
      xfer(1'h1, TSM_OFS_CTRL, 32'(c << 1));
      oh = (c >= 2 && c <= 5) ? 4'h1 << (c - 2) : 4'h0;
      for (int r = 0; r < 2; r++) begin
        for (int v = 0; v < 2; v++) begin
          @(posedge clk);
          rate106TypeA <= 1'(r);
          srcVec <= v ? oh : ~oh;
          look(32'(c == 1 || (c >= 2 && c <= 5 && (c < 4 || r == 1) && v == 1)));
        end
      end
    end
    xfer(1'h0, TSM_OFS_CTRL, 32'h0);
    chk("ctrl readback", rd, 32'hE);
    // Sources 4 and 5 ran at the wrong rate above, so the sticky flag must be up
    xfer(1'h0, TSM_OFS_STAT, 32'h0);
    chk("stat sticky", rd, (32'h1 << STAT_RATE_BIT) | (32'h1 << STAT_BLOCKED_BIT) | (32'h1 << STAT_SRC_RSVD_BIT));
    xfer(1'h1, TSM_OFS_STAT, 32'h1 << STAT_BLOCKED_BIT);
    xfer(1'h0, TSM_OFS_STAT, 32'h0);
    chk("stat cleared", rd, (32'h1 << STAT_RATE_BIT) | (32'h1 << STAT_SRC_RSVD_BIT));
    xfer(1'h1, TSM_OFS_CTRL, 32'h3);
    for (int i = 0; i < DIGI_CODE_COUNT; i++) begin
      xfer(1'h1, TSM_OFS_DIGI, 32'(DIGI_CODES[i]));
      for (int v = 0; v < 2; v++) begin
        @(posedge clk);
        probeVec <= v ? 9'h001 << i : ~(9'h001 << i);
        look(32'(v));
      end
    end
    xfer(1'h1, TSM_OFS_DIGI, 32'h0);
    look(32'h1);
    for (int a = 0; a < 32; a++) begin
      xfer(1'h1, TSM_OFS_ANA, 32'(a));
      repeat (3) @(posedge clk);
      #1;
      chk("analogNodeEnable", 32'(seenNodes), a < 13 ? 32'h1 << a : 32'h0);
    end
    summarize();
  end
endmodule : tb_top
